// file: charger_regs_pkg.sv
/*
  constants shared by the charger control register bank: byte offsets,
  reset values, field positions, cause-bit masks and control state codes.
  assumes: a byte-wide register port with a 4-bit offset.
*/
package charger_regs_pkg;

  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_STATE_POSITION = 4'h0;
  localparam logic [3:0] OFS_EVENT_CAUSE_FIRST = 4'h1;
  localparam logic [3:0] OFS_EVENT_CAUSE_SECOND = 4'h2;
  localparam logic [3:0] OFS_LIVE_CONDITION_FLAGS = 4'h3;
  localparam logic [3:0] OFS_UNUSED_SLOT = 4'h4;
  localparam logic [3:0] OFS_ACTION_TRIGGER = 4'h5;
  localparam logic [3:0] OFS_EVENT_MASK_FIRST = 4'h6;
  localparam logic [3:0] OFS_EVENT_MASK_SECOND = 4'h7;
  localparam logic [3:0] OFS_SETUP_FIRST = 4'h8;
  localparam logic [3:0] OFS_SETUP_SECOND = 4'h9;
  localparam logic [3:0] OFS_VOUT_CODE_HIGH = 4'hA;
  localparam logic [3:0] OFS_VOUT_CODE_LOW_AND_SETUP = 4'hB;
  localparam logic [3:0] OFS_CURRENT_LIMIT_CODE = 4'hC;
  localparam logic [3:0] OFS_AUX_REGULATOR_CODE = 4'hD;
  localparam logic [3:0] OFS_SETUP_FOURTH = 4'hE;
  localparam logic [3:0] OFS_SETUP_FIFTH = 4'hF;

  // ==========================================================
  // reset values (hard-coded bytes and default factory bytes)
  localparam logic [7:0] RST_ACTION_TRIGGER = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;
  localparam logic [7:0] RST_SETUP_FIRST = 8'h28;
  localparam logic [7:0] RST_SETUP_SECOND = 8'hF3;
  localparam logic [7:0] RST_VOUT_CODE_HIGH = 8'h32;
  localparam logic [7:0] RST_VOUT_CODE_LOW = 8'h10;
  localparam logic [7:0] RST_CURRENT_LIMIT = 8'hFF;
  localparam logic [7:0] RST_AUX_REGULATOR = 8'h30;
  localparam logic [7:0] RST_SETUP_FOURTH = 8'h23;
  localparam logic [7:0] RST_SETUP_FIFTH = 8'h9E;

  // ==========================================================
  // field positions and implemented-bit masks
  localparam int CMD_MAIN_ENABLE_BIT = 0;
  localparam int CMD_APPLY_VOLTAGE_BIT = 1;
  localparam int SETUP_MASK_ALL_BIT = 5;
  localparam logic [7:0] CAUSE_FIRST_USED = 8'hBD;
  localparam logic [7:0] CAUSE_SECOND_USED = 8'h7F;
  localparam logic [7:0] FLAGS_USED = 8'hFC;
  localparam logic [7:0] AUX_CODE_USED = 8'h3F;

  // ==========================================================
  // control state positions
  typedef enum logic [3:0] {
    ST_NO_POWER, ST_BIAS_START, ST_BIAS_RESET, ST_ADDR_CHECK,
    ST_BIAS_RAMP, ST_FREQ_CHECK, ST_FREQ_LOOP, ST_BIAS_READY,
    ST_MAIN_ENABLING, ST_MAIN_RAMP, ST_MAIN_ON, ST_MAIN_SHUTDOWN,
    ST_MAIN_ERROR
  } control_state_e;

endpackage

// file: charger_control_register_bank.sv
/*
  sixteen-byte control and status register bank of the charger.
  assumes: the serial bus engine outside hands over one byte access at a
  time as a one-cycle read or write strobe with offset and data; the
  analog control logic supplies its state code and live conditions.
*/
`timescale 1ns/1ps
`default_nettype none

module charger_control_register_bank #(
  // factory programmable defaults of bytes 6..F
  parameter logic [7:0] DEF_MASK_FIRST = charger_regs_pkg::RST_EVENT_MASK,
  parameter logic [7:0] DEF_MASK_SECOND = charger_regs_pkg::RST_EVENT_MASK,
  parameter logic [7:0] DEF_SETUP_FIRST = charger_regs_pkg::RST_SETUP_FIRST,
  parameter logic [7:0] DEF_SETUP_SECOND = charger_regs_pkg::RST_SETUP_SECOND,
  parameter logic [7:0] DEF_VOUT_HIGH = charger_regs_pkg::RST_VOUT_CODE_HIGH,
  parameter logic [7:0] DEF_VOUT_LOW = charger_regs_pkg::RST_VOUT_CODE_LOW,
  parameter logic [7:0] DEF_CURRENT_LIMIT_CODE = charger_regs_pkg::RST_CURRENT_LIMIT,
  parameter logic [7:0] DEF_AUX = charger_regs_pkg::RST_AUX_REGULATOR,
  parameter logic [7:0] DEF_SETUP_FOURTH = charger_regs_pkg::RST_SETUP_FOURTH,
  parameter logic [7:0] DEF_SETUP_FIFTH = charger_regs_pkg::RST_SETUP_FIFTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // byte access from the serial bus engine
  input wire logic [3:0] reg_offset,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // live inputs from the control logic and monitors
  input wire logic [3:0] control_state,
  input wire logic [7:0] cause_first_active,
  input wire logic [7:0] cause_second_active,
  input wire logic [7:0] condition_flags,
  // steering outputs
  output logic event_irq,
  output logic main_enable,
  output logic apply_voltage_code,
  output logic [10:0] output_voltage_code,
  output logic [7:0] current_limit_code,
  output logic [5:0] aux_regulator_voltage,
  output logic [7:0] setup_first,
  output logic [7:0] setup_second,
  output logic [4:0] setup_third,
  output logic [7:0] setup_fourth,
  output logic [7:0] setup_fifth
);

  // ==========================================================
  // helpers
  // clamp anything past the error code; the machine never reports it
  function automatic logic [3:0] legal_state(input logic [3:0] code);
    legal_state = (code > 4'(charger_regs_pkg::ST_MAIN_ERROR)) ?
      4'(charger_regs_pkg::ST_MAIN_ERROR) : code;
  endfunction

  // ==========================================================
  // register state
  logic [3:0] state_position, next_state_position; // sampled code
  logic [7:0] event_cause_first, next_event_cause_first;
  logic [7:0] event_cause_second, next_event_cause_second;
  logic [7:0] live_condition_flags, next_live_condition_flags;
  logic [7:0] event_mask_first, next_event_mask_first;
  logic [7:0] event_mask_second, next_event_mask_second;
  logic [7:0] vout_code_high, next_vout_code_high; // staged code
  logic [7:0] vout_code_low_and_setup, next_vout_code_low_and_setup;
  logic [7:0] next_setup_first, next_setup_second;
  logic [7:0] next_setup_fourth, next_setup_fifth;
  logic [7:0] next_current_limit_code;
  logic [5:0] next_aux_regulator_voltage;
  logic next_main_enable, next_apply_voltage_code, next_event_irq;
  logic [10:0] next_output_voltage_code; // applied code
  logic [7:0] next_reg_rdata;
  logic [7:0] mask_eff_first, mask_eff_second; // masks after mask-all
  logic [7:0] rd_mux; // byte seen by a read this cycle
  logic wr_cmd; // write to the command byte

  // ==========================================================
  // read multiplexer, reserved and unused bits are zero
  always_comb begin
    case (reg_offset)
      charger_regs_pkg::OFS_STATE_POSITION:
        rd_mux = {4'h0, state_position};
      charger_regs_pkg::OFS_EVENT_CAUSE_FIRST: rd_mux = event_cause_first;
      charger_regs_pkg::OFS_EVENT_CAUSE_SECOND: rd_mux = event_cause_second;
      charger_regs_pkg::OFS_LIVE_CONDITION_FLAGS:
        rd_mux = live_condition_flags;
      // apply bit never reads back
      charger_regs_pkg::OFS_ACTION_TRIGGER:
        rd_mux = {7'h00, main_enable};
      charger_regs_pkg::OFS_EVENT_MASK_FIRST: rd_mux = event_mask_first;
      charger_regs_pkg::OFS_EVENT_MASK_SECOND: rd_mux = event_mask_second;
      charger_regs_pkg::OFS_SETUP_FIRST: rd_mux = setup_first;
      charger_regs_pkg::OFS_SETUP_SECOND: rd_mux = setup_second;
      charger_regs_pkg::OFS_VOUT_CODE_HIGH: rd_mux = vout_code_high;
      charger_regs_pkg::OFS_VOUT_CODE_LOW_AND_SETUP:
        rd_mux = vout_code_low_and_setup;
      charger_regs_pkg::OFS_CURRENT_LIMIT_CODE: rd_mux = current_limit_code;
      charger_regs_pkg::OFS_AUX_REGULATOR_CODE:
        rd_mux = {2'b00, aux_regulator_voltage};
      charger_regs_pkg::OFS_SETUP_FOURTH: rd_mux = setup_fourth;
      charger_regs_pkg::OFS_SETUP_FIFTH: rd_mux = setup_fifth;
      default: rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // next-value logic for every byte
  always_comb begin
    next_state_position = legal_state(control_state);
    next_live_condition_flags = condition_flags &
      charger_regs_pkg::FLAGS_USED;
    // mask-all overrides both mask bytes internally
    mask_eff_first = event_mask_first |
      {8{setup_first[charger_regs_pkg::SETUP_MASK_ALL_BIT]}};
    mask_eff_second = event_mask_second |
      {8{setup_first[charger_regs_pkg::SETUP_MASK_ALL_BIT]}};
    // a read clears only resolved causes; a new event always wins
    next_event_cause_first = event_cause_first;
    next_event_cause_second = event_cause_second;
    if (reg_read &&
        reg_offset == charger_regs_pkg::OFS_EVENT_CAUSE_FIRST) begin
      next_event_cause_first = event_cause_first &
        cause_first_active;
    end
    if (reg_read &&
        reg_offset == charger_regs_pkg::OFS_EVENT_CAUSE_SECOND) begin
      next_event_cause_second = event_cause_second &
        cause_second_active;
    end
    next_event_cause_first = next_event_cause_first |
      (cause_first_active & charger_regs_pkg::CAUSE_FIRST_USED);
    next_event_cause_second = next_event_cause_second |
      (cause_second_active & charger_regs_pkg::CAUSE_SECOND_USED);
    // masked causes are still recorded but raise nothing
    next_event_irq = |(next_event_cause_first & ~mask_eff_first) |
      |(next_event_cause_second & ~mask_eff_second);
    // writable bytes; offsets 0..4 fall through untouched
    wr_cmd = reg_write && reg_offset == charger_regs_pkg::OFS_ACTION_TRIGGER;
    next_main_enable = main_enable;
    next_apply_voltage_code = 1'b0;
    next_event_mask_first = event_mask_first;
    next_event_mask_second = event_mask_second;
    next_setup_first = setup_first;
    next_setup_second = setup_second;
    next_vout_code_high = vout_code_high;
    next_vout_code_low_and_setup = vout_code_low_and_setup;
    next_current_limit_code = current_limit_code;
    next_aux_regulator_voltage = aux_regulator_voltage;
    next_setup_fourth = setup_fourth;
    next_setup_fifth = setup_fifth;
    if (wr_cmd) begin
      next_main_enable =
        reg_wdata[charger_regs_pkg::CMD_MAIN_ENABLE_BIT];
      next_apply_voltage_code =
        reg_wdata[charger_regs_pkg::CMD_APPLY_VOLTAGE_BIT];
    end
    if (reg_write) begin
      case (reg_offset)
        charger_regs_pkg::OFS_EVENT_MASK_FIRST:
          next_event_mask_first = reg_wdata;
        charger_regs_pkg::OFS_EVENT_MASK_SECOND:
          next_event_mask_second = reg_wdata;
        charger_regs_pkg::OFS_SETUP_FIRST: next_setup_first = reg_wdata;
        charger_regs_pkg::OFS_SETUP_SECOND: next_setup_second = reg_wdata;
        charger_regs_pkg::OFS_VOUT_CODE_HIGH: next_vout_code_high = reg_wdata;
        charger_regs_pkg::OFS_VOUT_CODE_LOW_AND_SETUP:
          next_vout_code_low_and_setup = reg_wdata;
        charger_regs_pkg::OFS_CURRENT_LIMIT_CODE:
          next_current_limit_code = reg_wdata;
        charger_regs_pkg::OFS_AUX_REGULATOR_CODE:
          next_aux_regulator_voltage = reg_wdata[5:0];
        charger_regs_pkg::OFS_SETUP_FOURTH: next_setup_fourth = reg_wdata;
        charger_regs_pkg::OFS_SETUP_FIFTH: next_setup_fifth = reg_wdata;
        default: ;
      endcase
    end
    // staged code only reaches the converter on an apply command
    next_output_voltage_code = output_voltage_code;
    if (wr_cmd && reg_wdata[charger_regs_pkg::CMD_APPLY_VOLTAGE_BIT]) begin
      next_output_voltage_code = {vout_code_high,
        vout_code_low_and_setup[7:5]};
    end
    next_reg_rdata = reg_read ? rd_mux : reg_rdata;
  end

  // ==========================================================
  // registers; bytes 0..5 fixed, 6..F from parameters
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_position <= 4'h0;
      event_cause_first <= 8'h00;
      event_cause_second <= 8'h00;
      live_condition_flags <= 8'h00;
      main_enable <= charger_regs_pkg::RST_ACTION_TRIGGER[0];
      apply_voltage_code <= 1'b0;
      event_irq <= 1'b0;
      reg_rdata <= 8'h00;
      event_mask_first <= DEF_MASK_FIRST;
      event_mask_second <= DEF_MASK_SECOND;
      setup_first <= DEF_SETUP_FIRST;
      setup_second <= DEF_SETUP_SECOND;
      vout_code_high <= DEF_VOUT_HIGH;
      vout_code_low_and_setup <= DEF_VOUT_LOW;
      output_voltage_code <= {DEF_VOUT_HIGH, DEF_VOUT_LOW[7:5]};
      current_limit_code <= DEF_CURRENT_LIMIT_CODE;
      aux_regulator_voltage <= DEF_AUX[5:0];
      setup_fourth <= DEF_SETUP_FOURTH;
      setup_fifth <= DEF_SETUP_FIFTH;
    end else begin
      state_position <= next_state_position;
      event_cause_first <= next_event_cause_first;
      event_cause_second <= next_event_cause_second;
      live_condition_flags <= next_live_condition_flags;
      main_enable <= next_main_enable;
      apply_voltage_code <= next_apply_voltage_code;
      event_irq <= next_event_irq;
      reg_rdata <= next_reg_rdata;
      event_mask_first <= next_event_mask_first;
      event_mask_second <= next_event_mask_second;
      setup_first <= next_setup_first;
      setup_second <= next_setup_second;
      vout_code_high <= next_vout_code_high;
      vout_code_low_and_setup <= next_vout_code_low_and_setup;
      output_voltage_code <= next_output_voltage_code;
      current_limit_code <= next_current_limit_code;
      aux_regulator_voltage <= next_aux_regulator_voltage;
      setup_fourth <= next_setup_fourth;
      setup_fifth <= next_setup_fifth;
    end
  end

  // low five bits of byte B are configuration
  assign setup_third = vout_code_low_and_setup[4:0];

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_state_upper_zero;
    reg_read && reg_offset == charger_regs_pkg::OFS_STATE_POSITION |=>
      reg_rdata[7:4] == 4'h0;
  endproperty
  a_state_upper_zero: assert property (p_state_upper_zero)
    else $error("state byte upper nibble not zero");
  property p_state_legal;
    reg_read && reg_offset == charger_regs_pkg::OFS_STATE_POSITION |=>
      reg_rdata[3:0] <= 4'hC;
  endproperty
  a_state_legal: assert property (p_state_legal)
    else $error("state code above main error reported");
  property p_state_follows;
    control_state <= 4'h7 |=> state_position == $past(control_state);
  endproperty
  a_state_follows: assert property (p_state_follows)
    else $error("bias state code not passed through");
  property p_cause_set;
    cause_second_active[5] |=> event_cause_second[5];
  endproperty
  a_cause_set: assert property (p_cause_set)
    else $error("active cause not recorded");
  property p_clear_on_read;
    reg_read && reg_offset == charger_regs_pkg::OFS_EVENT_CAUSE_FIRST &&
      cause_first_active == 8'h00 |=> event_cause_first == 8'h00;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("resolved cause survived read");
  property p_persist;
    reg_read && reg_offset == charger_regs_pkg::OFS_EVENT_CAUSE_SECOND &&
      event_cause_second[0] && cause_second_active[0] |=>
      event_cause_second[0];
  endproperty
  a_persist: assert property (p_persist)
    else $error("persisting cause cleared by read");
  property p_apply_reads_zero;
    reg_read && reg_offset == charger_regs_pkg::OFS_ACTION_TRIGGER |=>
      reg_rdata[7:1] == 7'h00;
  endproperty
  a_apply_reads_zero: assert property (p_apply_reads_zero)
    else $error("command byte upper bits read nonzero");
  // a second command right behind the first may keep the pulse high
  property p_apply_loads;
    reg_write && reg_offset == charger_regs_pkg::OFS_ACTION_TRIGGER &&
      reg_wdata[1] |=> apply_voltage_code &&
      output_voltage_code == {$past(vout_code_high),
      $past(vout_code_low_and_setup[7:5])} ##1
      (!apply_voltage_code || $past(wr_cmd));
  endproperty
  a_apply_loads: assert property (p_apply_loads)
    else $error("apply command did not load one-cycle");
  property p_mask_all;
    setup_first[5] && !(reg_write &&
      reg_offset == charger_regs_pkg::OFS_SETUP_FIRST) |=> !event_irq;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("interrupt raised under mask-all");
  // every recorded or arriving cause masked: nothing may be raised
  property p_mask_blocks;
    ((event_cause_first | cause_first_active) & ~event_mask_first) == 8'h00 &&
      ((event_cause_second | cause_second_active) & ~event_mask_second) ==
      8'h00 |=> !event_irq;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked cause raised interrupt");
  property p_ro_ignored;
    reg_write && reg_offset == charger_regs_pkg::OFS_UNUSED_SLOT |=>
      $stable(event_mask_first) && $stable(main_enable);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored)
    else $error("write to reserved byte had an effect");
  c_clear_read: cover property (reg_read &&
    reg_offset == charger_regs_pkg::OFS_EVENT_CAUSE_FIRST &&
    event_cause_first != 8'h00);
  c_apply: cover property (apply_voltage_code);
  c_irq: cover property (event_irq ##1 !event_irq);
  c_main_on: cover property (state_position == 4'hA);

endmodule

`default_nettype wire

// file: charger_host_model.sv
/*
  behavioural model of the serial bus engine that hands byte accesses to
  the charger register bank: one-cycle read and write strobes.
  assumes: strobes are taken on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module charger_host_model (
  input wire logic clk_sys,
  output logic [3:0] reg_offset,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ==========================================================
  // idle levels
  initial begin
    reg_offset = 4'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
  end

  // one write, launched at a falling edge and held over one rising edge
  task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
    @(negedge clk_sys);
    reg_offset = ofs;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk_sys);
    reg_write = 1'b0;
    // data is stale once taken, so it must not look valid
    reg_wdata = ~d;
  endtask

  // one read; the answer is registered at the taking edge
  task automatic rd(input logic [3:0] ofs, output logic [7:0] d);
    @(negedge clk_sys);
    reg_offset = ofs;
    reg_read = 1'b1;
    @(negedge clk_sys);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

// file: charger_control_register_bank_tb_top.sv
/*
  self-checking bench of the charger register bank with a host model.
  assumes: package charger_regs_pkg and the design compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module charger_control_register_bank_tb_top;
  // ==========================================================
  // signals
  logic clk_sys, reset_n;
  logic [3:0] reg_offset, control_state;
  logic reg_write, reg_read;
  logic [7:0] reg_wdata, reg_rdata, rv, p;
  logic [7:0] cause_first_active, cause_second_active, condition_flags;
  logic event_irq, main_enable, apply_voltage_code;
  logic [10:0] output_voltage_code;
  logic [7:0] current_limit_code, setup_first, setup_second;
  logic [7:0] setup_fourth, setup_fifth;
  logic [5:0] aux_regulator_voltage;
  logic [4:0] setup_third;
  logic [7:0] shadow [16]; // last written value of bytes 6..F
  int err_total, checks_done;

  charger_host_model host (.clk_sys(clk_sys), .reg_offset(reg_offset),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  charger_control_register_bank uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_offset(reg_offset), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .control_state(control_state), .cause_first_active(cause_first_active),
    .cause_second_active(cause_second_active),
    .condition_flags(condition_flags), .event_irq(event_irq),
    .main_enable(main_enable), .apply_voltage_code(apply_voltage_code),
    .output_voltage_code(output_voltage_code),
    .current_limit_code(current_limit_code),
    .aux_regulator_voltage(aux_regulator_voltage),
    .setup_first(setup_first), .setup_second(setup_second),
    .setup_third(setup_third), .setup_fourth(setup_fourth),
    .setup_fifth(setup_fifth));

  // ==========================================================
  // clock, 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // checking helpers
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [3:0] ofs, input logic [7:0] exp);
    host.rd(ofs, rv);
    check({3'h0, rv}, {3'h0, exp});
  endtask

  // reported code saturates at the error state
  function automatic logic [7:0] exp_state(input logic [3:0] v);
    return (v > 4'hC) ? 8'h0C : {4'h0, v};
  endfunction

  // bytes 6..F reset to their defaults, the rest read zero when idle
  function automatic logic [7:0] exp_reset(input logic [3:0] o);
    case (o)
      4'h8: return charger_regs_pkg::RST_SETUP_FIRST;
      4'h9: return charger_regs_pkg::RST_SETUP_SECOND;
      4'hA: return charger_regs_pkg::RST_VOUT_CODE_HIGH;
      4'hB: return charger_regs_pkg::RST_VOUT_CODE_LOW;
      4'hC: return charger_regs_pkg::RST_CURRENT_LIMIT;
      4'hD: return charger_regs_pkg::RST_AUX_REGULATOR;
      4'hE: return charger_regs_pkg::RST_SETUP_FOURTH;
      4'hF: return charger_regs_pkg::RST_SETUP_FIFTH;
      default: return 8'h00;
    endcase
  endfunction

  // pulse one cause for a cycle, sel picks the byte
  task automatic pulse_cause(input bit sel, input logic [7:0] v);
    @(negedge clk_sys);
    if (sel) cause_second_active = v;
    else cause_first_active = v;
    @(negedge clk_sys);
    cause_first_active = 8'h00;
    cause_second_active = 8'h00;
    @(negedge clk_sys);
  endtask

  task automatic give_verdict;
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(40 * 20000);
    err_total++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    reset_n = 1'b0;
    control_state = 4'h0;
    cause_first_active = 8'h00;
    cause_second_active = 8'h00;
    condition_flags = 8'h00;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    void'($urandom(32'h1d6e));
    // defaults at the steering outputs and in every byte
    check(output_voltage_code, 11'h190);
    check({3'h0, current_limit_code}, 11'h0FF);
    check({5'h0, aux_regulator_voltage}, 11'h030);
    check({3'h0, setup_first}, 11'h028);
    check({6'h0, setup_third}, 11'h010);
    check({3'h0, setup_second}, 11'h0F3);
    check({3'h0, setup_fourth}, 11'h023);
    check({3'h0, setup_fifth}, 11'h09E);
    for (int i = 0; i < 16; i++) rdc(i[3:0], exp_reset(i[3:0]));
    // every state code, including the unused ones above the error state
    for (int v = 0; v < 16; v++) begin
      @(negedge clk_sys);
      control_state = v[3:0];
      rdc(4'h0, exp_state(v[3:0]));
    end
    // live flags, unused low bits read zero
    for (int k = 0; k < 4; k++) begin
      p = 8'($urandom);
      condition_flags = p;
      rdc(4'h3, p & charger_regs_pkg::FLAGS_USED);
    end
    // writes to read-only and reserved bytes leave no trace
    for (int i = 0; i < 5; i++) begin
      host.wr(i[3:0], 8'($urandom) | 8'h01);
      rdc(i[3:0], (i == 0) ? 8'h0C : ((i == 3) ? p & 8'hFC : 8'h00));
    end
    check({10'h0, main_enable}, 11'h000);
    // all-ones, all-zeros, then random patterns into bytes 6..F
    for (int r = 0; r < 3; r++) begin
      for (int i = 6; i < 16; i++) begin
        shadow[i] = (r == 0) ? 8'hFF : ((r == 1) ? 8'h00 : 8'($urandom));
        host.wr(i[3:0], shadow[i]);
      end
      for (int i = 6; i < 16; i++)
        rdc(i[3:0], (i == 13) ? shadow[i] & 8'h3F : shadow[i]);
      check({3'h0, current_limit_code}, {3'h0, shadow[12]});
      check({5'h0, aux_regulator_voltage}, {5'h0, shadow[13][5:0]});
      check({3'h0, setup_first}, {3'h0, shadow[8]});
      check({3'h0, setup_second}, {3'h0, shadow[9]});
      check({6'h0, setup_third}, {6'h0, shadow[11][4:0]});
      check({3'h0, setup_fourth}, {3'h0, shadow[14]});
      check({3'h0, setup_fifth}, {3'h0, shadow[15]});
    end
    // staged voltage code waits for the apply command
    check(output_voltage_code, 11'h190);
    host.wr(4'h5, 8'h02);
    check({10'h0, apply_voltage_code}, 11'h001);
    check(output_voltage_code, {shadow[10], shadow[11][7:5]});
    @(negedge clk_sys);
    check({10'h0, apply_voltage_code}, 11'h000);
    rdc(4'h5, 8'h00);
    // apply bit set again so its read-back zero is seen beside enable
    host.wr(4'h5, 8'h03);
    check({10'h0, main_enable}, 11'h001);
    rdc(4'h5, 8'h01);
    // cause bytes: record, clear on read, persist, mask, mask-all
    host.wr(4'h8, 8'h00);
    host.wr(4'h6, 8'h00);
    host.wr(4'h7, 8'h00);
    for (int s = 0; s < 2; s++) begin
      p = (8'($urandom) | 8'h01) & (s ? 8'h7F : 8'hBD);
      pulse_cause(s[0], p);
      check({10'h0, event_irq}, 11'h001);
      rdc(4'h1 + s[3:0], p);
      rdc(4'h1 + s[3:0], 8'h00);
      check({10'h0, event_irq}, 11'h000);
      @(negedge clk_sys);
      if (s) cause_second_active = p;
      else cause_first_active = p;
      rdc(4'h1 + s[3:0], p);
      rdc(4'h1 + s[3:0], p);
      pulse_cause(s[0], 8'h00);
      rdc(4'h1 + s[3:0], p);
      host.wr(4'h6 + s[3:0], 8'hFF);
      pulse_cause(s[0], p);
      check({10'h0, event_irq}, 11'h000);
      rdc(4'h1 + s[3:0], p);
      host.wr(4'h6 + s[3:0], 8'h00);
      host.wr(4'h8, 8'h20);
      pulse_cause(s[0], p);
      check({10'h0, event_irq}, 11'h000);
      host.wr(4'h8, 8'h00);
      @(negedge clk_sys);
      check({10'h0, event_irq}, 11'h001);
      rdc(4'h1 + s[3:0], p);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
